// >>> hw/tec_pkg.sv
// Purpose: Shared constants for the T1 error counter and interrupt mask block
// Assumes: 125 MHz core clock, 8-bit control port with byte-wide registers
// Notes:   Offsets are byte addresses on the control port
package tec_pkg;
   // Register offsets
   localparam logic [7:0] LINE_CNT_HIGH_ADDR = 8'h23;
   localparam logic [7:0] LINE_CNT_LOW_ADDR  = 8'h24;
   localparam logic [7:0] PATH_CNT_HIGH_ADDR = 8'h25;
   localparam logic [7:0] PATH_CNT_LOW_ADDR  = 8'h26;
   localparam logic [7:0] MOS_CNT_LOW_ADDR   = 8'h27;
   localparam logic [7:0] EVENT_MASK_B_ADDR  = 8'h6f;
   localparam logic [7:0] ALARM_MASK_A_ADDR  = 8'h7f;

   // Reset values
   localparam logic [7:0] MASK_RESET  = 8'h00;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

   // Counter widths
   localparam int LINE_CNT_W = 16;
   localparam int PATH_CNT_W = 12;
   localparam int MOS_CNT_W  = 12;

   // Zero run lengths counted as line errors
   localparam logic [4:0] ZERO_RUN_PLAIN = 5'h10;
   localparam logic [4:0] ZERO_RUN_SUBST = 5'h08;

   // Interval timing
   localparam longint CLK_PERIOD_NS   = 8;
   localparam longint ONE_SEC_NS      = 1000000000;
   localparam longint SHORT_IVL_NS    = 42000000;
   localparam longint ONE_SEC_CYCLES  = ONE_SEC_NS / CLK_PERIOD_NS;
   localparam longint SHORT_IVL_CYCLES = SHORT_IVL_NS / CLK_PERIOD_NS;
   localparam int     IVL_CNT_W       = 27;
endpackage

// >>> hw/tec_sat_counter.sv
// Purpose: Saturating working counter with a held copy taken at each boundary
// Assumes: boundary is a one-cycle pulse on clk
// Notes:   Events in the boundary cycle land in the held copy, none are lost
`timescale 1ns/1ps
module tec_sat_counter #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [1:0]       inc_amt,
   input  wire logic             boundary,
   output logic      [WIDTH-1:0] held
);
   localparam logic [WIDTH:0] MAX_VAL = {1'b0, {WIDTH{1'b1}}};

   // Elaboration check on the counter width
   if (WIDTH < 2 || WIDTH > 31) begin : g_bad_width
      $error("tec_sat_counter: WIDTH out of range");
   end

   logic [WIDTH-1:0] work_reg;
   logic [WIDTH-1:0] work_next;
   logic [WIDTH:0]   sum;

   // Saturating sum, never wraps
   always_comb begin
      sum = {1'b0, work_reg} + {{(WIDTH-1){1'b0}}, inc_amt};
      if (sum > MAX_VAL) begin
         work_next = MAX_VAL[WIDTH-1:0];
      end else begin
         work_next = sum[WIDTH-1:0];
      end
   end

   // Working count, restarted on boundary
   always_ff @(posedge clk) begin
      if (!rstn) begin
         work_reg <= '0;
      end else if (boundary) begin
         work_reg <= '0;
      end else begin
         work_reg <= work_next;
      end
   end

   // Held copy of the last complete interval
   always_ff @(posedge clk) begin
      if (!rstn) begin
         held <= '0;
      end else if (boundary) begin
         held <= work_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_sat_no_wrap: assert property (
      work_reg == MAX_VAL[WIDTH-1:0] && !boundary |=> work_reg == MAX_VAL[WIDTH-1:0])
      else $error("counter left its maximum");
   a_snap_copy: assert property (
      boundary |=> held == $past(work_next) && work_reg == '0)
      else $error("boundary copy or restart wrong");
   a_held_steady: assert property (
      !boundary |=> held == $past(held))
      else $error("held count changed between boundaries");
endmodule

// >>> hw/tec_error_counters.sv
// Purpose: T1 receive error counters with interval snapshot and interrupt masks
// Assumes: Event inputs come from framer logic on clk; no synchronisers needed
// Notes:   Control port is a synchronous byte port; reads answer one cycle later
`timescale 1ns/1ps
module tec_error_counters #(
   parameter longint ONE_SEC_CYC  = tec_pkg::ONE_SEC_CYCLES,
   parameter longint SHORT_IVL_CYC = tec_pkg::SHORT_IVL_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   // Control port
   input  wire logic [7:0] bus_addr,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   input  wire logic [7:0] bus_wdata,
   output logic      [7:0] bus_rdata,
   // Configuration bits held elsewhere
   input  wire logic       interval_select,
   input  wire logic       count_zeros_enable,
   input  wire logic       zero_substitution_enable,
   input  wire logic       frame_format_select,
   input  wire logic       fs_error_count_enable,
   // Line decoder events
   input  wire logic       bpv_event,
   input  wire logic       subst_codeword,
   input  wire logic       rx_bit_valid,
   input  wire logic       rx_bit_zero,
   // Framer events
   input  wire logic       rx_sync_loss,
   input  wire logic       crc_error_event,
   input  wire logic       ft_error_event,
   input  wire logic       fs_error_event,
   input  wire logic       mos_count_event,
   // Status bits to be gated
   input  wire logic [7:0] alarm_status_a,
   input  wire logic [7:0] event_status_b,
   output logic            irq,
   output logic            interval_tick
);
   // Elaboration checks on the interval lengths
   if (ONE_SEC_CYC < 2 || ONE_SEC_CYC >= (64'h1 << tec_pkg::IVL_CNT_W)) begin : g_bad_sec
      $error("tec_error_counters: ONE_SEC_CYC out of range");
   end
   if (SHORT_IVL_CYC < 2 || SHORT_IVL_CYC > ONE_SEC_CYC) begin : g_bad_short
      $error("tec_error_counters: SHORT_IVL_CYC out of range");
   end

   localparam logic [tec_pkg::IVL_CNT_W-1:0] SEC_LAST =
      tec_pkg::IVL_CNT_W'(ONE_SEC_CYC - 1);
   localparam logic [tec_pkg::IVL_CNT_W-1:0] SHORT_LAST =
      tec_pkg::IVL_CNT_W'(SHORT_IVL_CYC - 1);

   logic [7:0]                     alarm_irq_mask_a_reg;
   logic [7:0]                     event_irq_mask_b_reg;
   logic [tec_pkg::IVL_CNT_W-1:0]  ivl_cnt_reg;
   logic [tec_pkg::IVL_CNT_W-1:0]  ivl_last;
   logic                           boundary;
   logic [4:0]                     zero_run_reg;
   logic [4:0]                     zero_limit;
   logic                           zero_event;
   logic                           bpv_counted;
   logic [1:0]                     line_inc;
   logic                           path_hit;
   logic [1:0]                     path_inc;
   logic [1:0]                     mos_inc;
   logic [tec_pkg::LINE_CNT_W-1:0] line_held;
   logic [tec_pkg::PATH_CNT_W-1:0] path_held;
   logic [tec_pkg::MOS_CNT_W-1:0]  mos_held;

   // Mask registers, written from the control port
   always_ff @(posedge clk) begin
      if (!rstn) begin
         alarm_irq_mask_a_reg <= tec_pkg::MASK_RESET;
         event_irq_mask_b_reg <= tec_pkg::MASK_RESET;
      end else if (bus_wr) begin
         if (bus_addr == tec_pkg::ALARM_MASK_A_ADDR) begin
            alarm_irq_mask_a_reg <= bus_wdata;
         end else if (bus_addr == tec_pkg::EVENT_MASK_B_ADDR) begin
            event_irq_mask_b_reg <= bus_wdata;
         end
      end
   end

   // Interrupt request from masked status
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((alarm_status_a & alarm_irq_mask_a_reg) |
                  (event_status_b & event_irq_mask_b_reg));
      end
   end

   // Interval timer, length picked by interval select
   assign ivl_last = interval_select ? SHORT_LAST : SEC_LAST;
   assign boundary = (ivl_cnt_reg >= ivl_last);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ivl_cnt_reg <= '0;
      end else if (boundary) begin
         ivl_cnt_reg <= '0;
      end else begin
         ivl_cnt_reg <= ivl_cnt_reg + 1'b1;
      end
   end

   // Tick output for software timing of reads
   always_ff @(posedge clk) begin
      if (!rstn) begin
         interval_tick <= 1'b0;
      end else begin
         interval_tick <= boundary;
      end
   end

   // Excess zero detector
   assign zero_limit = zero_substitution_enable ? tec_pkg::ZERO_RUN_SUBST
                                                : tec_pkg::ZERO_RUN_PLAIN;
   assign zero_event = count_zeros_enable && rx_bit_valid && rx_bit_zero &&
                       (zero_run_reg == zero_limit - 5'h01);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         zero_run_reg <= '0;
      end else if (rx_bit_valid) begin
         if (!rx_bit_zero || zero_event) begin
            zero_run_reg <= '0;
         end else if (zero_run_reg < zero_limit) begin
            zero_run_reg <= zero_run_reg + 5'h01;
         end
      end
   end

   // Line increments, never gated by sync loss
   assign bpv_counted = bpv_event && !(zero_substitution_enable && subst_codeword);
   assign line_inc    = {1'b0, bpv_counted} + {1'b0, zero_event};

   // Path increments by framing mode, held off during sync loss
   always_comb begin
      if (frame_format_select) begin
         path_hit = crc_error_event;
      end else begin
         path_hit = ft_error_event || (fs_error_count_enable && fs_error_event);
      end
   end
   assign path_inc = {1'b0, path_hit && !rx_sync_loss};
   assign mos_inc  = {1'b0, mos_count_event};

   tec_sat_counter #(.WIDTH(tec_pkg::LINE_CNT_W)) u_line_cnt (
      .clk      (clk),
      .rstn     (rstn),
      .inc_amt  (line_inc),
      .boundary (boundary),
      .held     (line_held)
   );

   tec_sat_counter #(.WIDTH(tec_pkg::PATH_CNT_W)) u_path_cnt (
      .clk      (clk),
      .rstn     (rstn),
      .inc_amt  (path_inc),
      .boundary (boundary),
      .held     (path_held)
   );

   tec_sat_counter #(.WIDTH(tec_pkg::MOS_CNT_W)) u_mos_cnt (
      .clk      (clk),
      .rstn     (rstn),
      .inc_amt  (mos_inc),
      .boundary (boundary),
      .held     (mos_held)
   );

   // Read data, registered, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bus_rdata <= tec_pkg::UNMAPPED_RD;
      end else if (bus_rd) begin
         if (bus_addr == tec_pkg::LINE_CNT_HIGH_ADDR) begin
            bus_rdata <= line_held[15:8];
         end else if (bus_addr == tec_pkg::LINE_CNT_LOW_ADDR) begin
            bus_rdata <= line_held[7:0];
         end else if (bus_addr == tec_pkg::PATH_CNT_HIGH_ADDR) begin
            bus_rdata <= {mos_held[11:8], path_held[11:8]};
         end else if (bus_addr == tec_pkg::PATH_CNT_LOW_ADDR) begin
            bus_rdata <= path_held[7:0];
         end else if (bus_addr == tec_pkg::MOS_CNT_LOW_ADDR) begin
            bus_rdata <= mos_held[7:0];
         end else if (bus_addr == tec_pkg::EVENT_MASK_B_ADDR) begin
            bus_rdata <= event_irq_mask_b_reg;
         end else if (bus_addr == tec_pkg::ALARM_MASK_A_ADDR) begin
            bus_rdata <= alarm_irq_mask_a_reg;
         end else begin
            bus_rdata <= tec_pkg::UNMAPPED_RD;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Interrupt gating
   a_irq_gated_on: assert property (
      |((alarm_status_a & alarm_irq_mask_a_reg) | (event_status_b & event_irq_mask_b_reg))
      |=> irq)
      else $error("unmasked status did not raise irq");
   a_irq_gated_off: assert property (
      ((alarm_status_a & alarm_irq_mask_a_reg) == 8'h00 &&
       (event_status_b & event_irq_mask_b_reg) == 8'h00) |=> !irq)
      else $error("irq high with all status masked");

   // Mask registers
   a_mask_a_write: assert property (
      bus_wr && bus_addr == tec_pkg::ALARM_MASK_A_ADDR
      |=> alarm_irq_mask_a_reg == $past(bus_wdata))
      else $error("mask A not written");
   a_mask_a_read: assert property (
      bus_rd && bus_addr == tec_pkg::ALARM_MASK_A_ADDR
      |=> bus_rdata == $past(alarm_irq_mask_a_reg))
      else $error("mask A readback wrong");
   a_mask_b_write: assert property (
      bus_wr && bus_addr == tec_pkg::EVENT_MASK_B_ADDR
      |=> event_irq_mask_b_reg == $past(bus_wdata))
      else $error("mask B not written");
   a_mask_b_read: assert property (
      bus_rd && bus_addr == tec_pkg::EVENT_MASK_B_ADDR
      |=> bus_rdata == $past(event_irq_mask_b_reg))
      else $error("mask B readback wrong");
   a_mask_hold: assert property (
      !bus_wr |=> $stable(alarm_irq_mask_a_reg) && $stable(event_irq_mask_b_reg))
      else $error("mask changed without a write");

   // Interval timer and tick
   a_interval_len: assert property (
      boundary && $stable(interval_select)
      |-> ivl_cnt_reg == (interval_select ? SHORT_LAST : SEC_LAST))
      else $error("boundary at wrong count");
   a_ivl_no_overrun: assert property (
      ivl_cnt_reg > ivl_last |-> $changed(interval_select))
      else $error("interval timer ran past its last count");
   a_tick_follows: assert property (
      boundary |=> interval_tick)
      else $error("tick missing after boundary");

   // Line counter
   a_line_read: assert property (
      bus_rd && bus_addr == tec_pkg::LINE_CNT_HIGH_ADDR
      |=> bus_rdata == $past(line_held[15:8]))
      else $error("line high byte read wrong");
   a_line_low_read: assert property (
      bus_rd && bus_addr == tec_pkg::LINE_CNT_LOW_ADDR
      |=> bus_rdata == $past(line_held[7:0]))
      else $error("line low byte read wrong");
   a_zero_run: assert property (
      zero_event |-> zero_run_reg == (zero_substitution_enable ? 5'h07 : 5'h0f))
      else $error("zero run counted at wrong length");
   a_codeword_drop: assert property (
      zero_substitution_enable && subst_codeword && !zero_event |-> line_inc == 2'h0)
      else $error("substitution codeword counted");
   a_line_always_on: assert property (
      bpv_event && !subst_codeword |-> line_inc != 2'h0)
      else $error("violation not counted");
   a_line_double: assert property (
      bpv_event && !subst_codeword && zero_event |-> line_inc == 2'h2)
      else $error("simultaneous line events not both counted");

   // Path and multiframe counters
   a_path_esf: assert property (
      frame_format_select && crc_error_event && !rx_sync_loss |-> path_inc == 2'h1)
      else $error("crc error not counted");
   a_path_esf_only: assert property (
      frame_format_select && !crc_error_event |-> path_inc == 2'h0)
      else $error("framing error counted in ESF");
   a_path_ft: assert property (
      !frame_format_select && ft_error_event && !rx_sync_loss |-> path_inc == 2'h1)
      else $error("ft error not counted");
   a_path_fs: assert property (
      !frame_format_select && fs_error_count_enable && fs_error_event && !rx_sync_loss
      |-> path_inc == 2'h1)
      else $error("fs error not counted");
   a_path_sync_loss: assert property (
      rx_sync_loss |-> path_inc == 2'h0)
      else $error("path counted during sync loss");
   a_path_high_read: assert property (
      bus_rd && bus_addr == tec_pkg::PATH_CNT_HIGH_ADDR
      |=> bus_rdata == $past({mos_held[11:8], path_held[11:8]}))
      else $error("shared high byte read wrong");
   a_path_low_read: assert property (
      bus_rd && bus_addr == tec_pkg::PATH_CNT_LOW_ADDR
      |=> bus_rdata == $past(path_held[7:0]))
      else $error("path low byte read wrong");
   a_mos_low_read: assert property (
      bus_rd && bus_addr == tec_pkg::MOS_CNT_LOW_ADDR
      |=> bus_rdata == $past(mos_held[7:0]))
      else $error("multiframe low byte read wrong");

   // Main scenarios
   c_boundary_short: cover property (interval_select && boundary);
   c_irq_raise: cover property (!irq ##1 irq);
   c_zero_run: cover property (zero_event && zero_substitution_enable);
   c_path_blocked: cover property (rx_sync_loss && crc_error_event);
   c_path_full: cover property (path_held == 12'hfff);
endmodule

// >>> verification/tb.sv
// Purpose: Self-checking bench for the T1 error counter and interrupt mask block
// Assumes: Intervals of 5000 and 20 cycles stand in for the 1 s and 42 ms periods
// Notes:   Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module tb;
   localparam longint LONG_IVL  = 5000;
   localparam longint SHORT_IVL = 20;
   logic       clk = 1'b0;
   logic       rstn;
   logic [7:0] bus_addr;
   logic       bus_wr;
   logic       bus_rd;
   logic [7:0] bus_wdata;
   logic [7:0] bus_rdata;
   logic [3:0] cfg;
   logic       ivl_sel;
   logic [8:0] ev;
   logic [7:0] st_a;
   logic [7:0] st_b;
   logic       irq;
   logic       interval_tick;
   int         err_total = 0;
   int         check_count = 0;
   int         cyc = 0;

   tec_error_counters #(
      .ONE_SEC_CYC  (LONG_IVL),
      .SHORT_IVL_CYC(SHORT_IVL)
   ) i_dut (
      .clk                     (clk),
      .rstn                    (rstn),
      .bus_addr                (bus_addr),
      .bus_wr                  (bus_wr),
      .bus_rd                  (bus_rd),
      .bus_wdata               (bus_wdata),
      .bus_rdata               (bus_rdata),
      .interval_select         (ivl_sel),
      .count_zeros_enable      (cfg[3]),
      .zero_substitution_enable(cfg[2]),
      .frame_format_select     (cfg[1]),
      .fs_error_count_enable   (cfg[0]),
      .bpv_event               (ev[8]),
      .subst_codeword          (ev[7]),
      .rx_bit_valid            (ev[6]),
      .rx_bit_zero             (ev[5]),
      .rx_sync_loss            (ev[4]),
      .crc_error_event         (ev[3]),
      .ft_error_event          (ev[2]),
      .fs_error_event          (ev[1]),
      .mos_count_event         (ev[0]),
      .alarm_status_a          (st_a),
      .event_status_b          (st_b),
      .irq                     (irq),
      .interval_tick           (interval_tick)
   );

   // Clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (err_total == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Expected interrupt level from masks and status
   function automatic logic [15:0] exp_irq(input logic [15:0] m, input logic [15:0] s);
      return {15'h0, |(m & s)};
   endfunction

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   // One-cycle read strobe, data taken a cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(negedge clk);
      d = bus_rdata;
   endtask

   // Wait for the interval tick, counting cycles
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (interval_tick !== 1'b1 && n < 6000);
      chk("tick seen", {15'h0, interval_tick}, 16'h0001);
   endtask

   task automatic set_status(input logic [15:0] s);
      @(posedge clk);
      {st_b, st_a} <= s;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   // Events for n cycles inside one interval, then read the held counts
   task automatic ivl(input string what, input logic [3:0] c, input logic [8:0] e, input int n,
                      input int el, input int ep, input int em);
      int         w;
      logic [7:0] b0, b1, b2, b3, b4;
      wait_tick(w);
      @(posedge clk);
      cfg <= c;
      ev  <= e;
      repeat (n) @(posedge clk);
      ev <= '0;
      wait_tick(w);
      rd(tec_pkg::LINE_CNT_HIGH_ADDR, b0);
      rd(tec_pkg::LINE_CNT_LOW_ADDR, b1);
      rd(tec_pkg::PATH_CNT_HIGH_ADDR, b2);
      rd(tec_pkg::PATH_CNT_LOW_ADDR, b3);
      rd(tec_pkg::MOS_CNT_LOW_ADDR, b4);
      chk({what, " line"}, {b0, b1}, 16'(el));
      chk({what, " path"}, {4'h0, b2[3:0], b3}, 16'(ep));
      chk({what, " mos"}, {4'h0, b2[7:4], b4}, 16'(em));
   endtask

   initial begin
      int          p;
      int          r;
      logic [7:0]  d;
      logic [15:0] m;
      logic [15:0] s;
      logic [7:0]  addrs [8];
      addrs = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h6f, 8'h7f, 8'h40};
      rstn = 1'b0;
      bus_addr = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
      cfg = 4'h0;
      ivl_sel = 1'b1;
      ev = 9'h000;
      st_a = 8'h00;
      st_b = 8'h00;
      void'($urandom(2));
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      // Reset values; counter and unmapped writes ignored
      wr(tec_pkg::LINE_CNT_HIGH_ADDR, 8'h5a);
      wr(8'h40, 8'ha5);
      foreach (addrs[i]) begin
         rd(addrs[i], d);
         chk("reset read", {8'h00, d}, 16'h0000);
      end
      // Walking mask bit against matching and other status bits
      for (int i = 0; i < 16; i++) begin
         m = 16'h0001 << i;
         wr(tec_pkg::ALARM_MASK_A_ADDR, m[7:0]);
         wr(tec_pkg::EVENT_MASK_B_ADDR, m[15:8]);
         set_status(m);
         chk("irq own bit", {15'h0, irq}, 16'h0001);
         set_status(~m);
         chk("irq other bits", {15'h0, irq}, 16'h0000);
      end
      // Random masks and status
      repeat (24) begin
         m = 16'($urandom);
         s = 16'($urandom);
         wr(tec_pkg::ALARM_MASK_A_ADDR, m[7:0]);
         wr(tec_pkg::EVENT_MASK_B_ADDR, m[15:8]);
         set_status(s);
         chk("irq masked or", {15'h0, irq}, exp_irq(m, s));
         rd(tec_pkg::ALARM_MASK_A_ADDR, d);
         chk("mask a", {8'h00, d}, {8'h00, m[7:0]});
         rd(tec_pkg::EVENT_MASK_B_ADDR, d);
         chk("mask b", {8'h00, d}, {8'h00, m[15:8]});
      end
      // Short interval period
      wait_tick(p);
      wait_tick(p);
      chk("short period", 16'(p), 16'(SHORT_IVL));
      // Line counting modes
      r = $urandom_range(15, 1);
      ivl("bpv", 4'h0, 9'h100, r, r, 0, 0);
      r = $urandom_range(15, 1);
      ivl("codeword no subst", 4'h0, 9'h180, r, r, 0, 0);
      ivl("zeros 16", 4'h8, 9'h160, 16, 17, 0, 0);
      ivl("zeros 8 subst", 4'hc, 9'h1e0, 16, 2, 0, 0);
      ivl("codeword subst", 4'h4, 9'h1e0, 16, 0, 0, 0);
      // Path counting modes and sync loss
      r = $urandom_range(15, 1);
      ivl("esf crc", 4'h2, 9'h00e, r, 0, r, 0);
      r = $urandom_range(15, 1);
      ivl("d4 ft", 4'h0, 9'h00e, r, 0, r, 0);
      ivl("d4 fs", 4'h1, 9'h002, 15, 0, 15, 0);
      ivl("d4 fs off", 4'h0, 9'h002, 1, 0, 0, 0);
      r = $urandom_range(15, 1);
      ivl("sync loss", 4'h2, 9'h119, r, r, 0, r);
      // Long interval, saturation, then clearing
      @(posedge clk);
      ivl_sel <= 1'b0;
      wait_tick(p);
      wait_tick(p);
      chk("long period", 16'(p), 16'(LONG_IVL));
      ivl("saturate", 4'h2, 9'h009, 4200, 0, 4095, 4095);
      ivl("after saturate", 4'h2, 9'h000, 1, 0, 0, 0);
      end_of_test();
   end
endmodule
